// *** inc/bccd_pkg.sv ***
// Constants and types for the battery charger command decoder
package bccd_pkg;
   // Serial word and frame geometry
   localparam int BCCD_WORD_BITS = 22;
   localparam int BCCD_RESULT_BITS = 10;
   localparam int BCCD_STATUS_BITS = 8;
   localparam int BCCD_FRAME_BITS = 28;
   localparam logic [21:0] BCCD_CFG_RESET = 22'h000000;
   localparam logic [4:0] BCCD_POS_START = 5'h01;
   localparam logic [4:0] BCCD_POS_FIRST = 5'h02;
   localparam logic [4:0] BCCD_POS_LAST = 5'h16;
   localparam logic [4:0] BCCD_LEN_MSB_ONLY = 5'h12;
   localparam logic [4:0] BCCD_LEN_BOTH = 5'h1C;
   localparam int BCCD_FAULT_CLEAR_IDX = 16;
   // Timing of the fail-safe timer
   localparam longint BCCD_CLK_HZ = 200000000;
   localparam longint BCCD_MINUTE_S = 60;
   localparam longint BCCD_MINUTE_CYCLES = BCCD_CLK_HZ * BCCD_MINUTE_S;
   localparam logic [8:0] BCCD_TIMEOUT_BASE_MIN = 9'h005;
   localparam logic [2:0] BCCD_TIMEOUT_OFF = 3'h7;
   localparam logic [2:0] BCCD_DUTY_FULL = 3'h4;
   localparam logic [4:0] BCCD_ONE_SLOT = 5'h01;
   localparam logic [2:0] BCCD_PIN_RESET = 3'h1;

   // Operating mode, high bit then low bit
   typedef enum logic [1:0] {
      BCCD_IDLE,
      BCCD_DISCHARGE,
      BCCD_CHARGE,
      BCCD_GAUGE
   } bccd_mode_t;

   // Serial port sequencer
   typedef enum logic [1:0] {
      BCCD_WAIT_START,
      BCCD_CAPTURE,
      BCCD_SEND,
      BCCD_DONE
   } bccd_state_t;

   // Stored command word, bit p-1 holds position p
   typedef struct packed {
      logic sense_reference_select1;
      logic sense_reference_select0;
      logic [2:0] timeout_select;
      logic fault_latch_clear;
      logic [2:0] loop_duty_ratio;
      logic power_down_bit;
      logic [3:0] attenuator_ratio;
      logic [2:0] adc_source_select;
      logic high_bit_first;
      logic adc_input_polarity;
      logic operating_mode_high;
      logic operating_mode_low;
      logic start;
   } bccd_cfg_t;
endpackage : bccd_pkg

// *** rtl/bccd_top.sv ***
// Serial command receiver and decoder of the battery charger
`timescale 1ns/1ps
module bccd_top import bccd_pkg::*; #(
   parameter logic [33:0] MINUTE_CYCLES = 34'(BCCD_MINUTE_CYCLES)
) (
   input wire logic i_sys_clk,
   input wire logic i_rst_b,
   input wire logic i_ce,
   input wire logic i_cs_b,
   input wire logic i_sclk,
   input wire logic i_din,
   input wire logic [9:0] i_adc_result,
   input wire logic [7:0] i_status,
   output logic o_dout,
   output logic o_dout_en_b,
   output logic [1:0] o_mode,
   output logic o_power_down,
   output logic o_analog_on,
   output logic o_regulator_on,
   output logic o_divider_connect,
   output logic o_discharge_en,
   output logic o_charge_en,
   output logic o_gauge_en,
   output logic o_adc_ref_sense,
   output logic [2:0] o_adc_source,
   output logic [4:0] o_divide_by,
   output logic [4:0] o_loop_slots,
   output logic [1:0] o_sense_ref,
   output logic o_fault_clear,
   output logic o_timeout
);

   // Refuse a minute length the prescaler cannot count
   if (MINUTE_CYCLES == 34'h0) begin : g_bad_minute
      $error("MINUTE_CYCLES must be nonzero");
   end

   logic [2:0] pin_meta;
   logic [2:0] pin_sync;
   logic sclk_prev;
   logic cs_low_prev;
   bccd_state_t state;
   bccd_state_t next_state;
   logic [4:0] bit_pos;
   logic [4:0] next_bit_pos;
   logic [21:0] cfg_word;
   logic [27:0] out_sr;
   logic [4:0] out_left;
   logic [33:0] prescale;
   logic [8:0] minutes;

   // Pins pass two flip-flops: cs_b, sclk, din
   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         pin_meta <= BCCD_PIN_RESET;
         pin_sync <= BCCD_PIN_RESET;
         sclk_prev <= 1'b0;
         cs_low_prev <= 1'b0;
      end else if (i_ce) begin
         pin_meta <= {i_din, i_sclk, i_cs_b};
         pin_sync <= pin_meta;
         sclk_prev <= pin_sync[1];
         cs_low_prev <= !pin_sync[0];
      end
   end

   // Edge and level decode of the synchronised pins
   wire cs_low = !pin_sync[0];
   wire din_bit = pin_sync[2];
   wire sclk_rise = pin_sync[1] && !sclk_prev;
   wire sclk_fall = !pin_sync[1] && sclk_prev;
   wire cs_rise = cs_low_prev && !cs_low;
   wire in_wait = (state == BCCD_WAIT_START);
   wire in_capture = (state == BCCD_CAPTURE);
   wire capture_en = cs_low && sclk_rise &&
      (in_capture || (in_wait && din_bit));
   wire word_done = capture_en && in_capture &&
      (bit_pos == BCCD_POS_LAST);
   wire send_bit = (state == BCCD_SEND) && cs_low && sclk_fall;

   // Stored word seen through its field layout
   bccd_cfg_t cfg;
   assign cfg = bccd_cfg_t'(cfg_word);

   // One capture flop per word position
   for (genvar k = 0; k < BCCD_WORD_BITS; k++) begin : g_cfg
      wire hit = capture_en && (bit_pos == 5'(k + 1));
      wire drop = (k == BCCD_FAULT_CLEAR_IDX) && cs_rise;
      always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
         if (!i_rst_b) begin
            cfg_word[k] <= BCCD_CFG_RESET[k];
         end else if (i_ce) begin
            if (hit) begin
               cfg_word[k] <= din_bit;
            end else if (drop) begin
               cfg_word[k] <= 1'b0;
            end
         end
      end
   end

   // Sequencer next state
   always_comb begin
      next_state = state;
      next_bit_pos = bit_pos;
      if (!cs_low) begin
         next_state = BCCD_WAIT_START;
         next_bit_pos = BCCD_POS_START;
      end else begin
         case (state)
            BCCD_WAIT_START: begin
               if (capture_en) begin
                  next_state = BCCD_CAPTURE;
                  next_bit_pos = BCCD_POS_FIRST;
               end
            end
            BCCD_CAPTURE: begin
               if (word_done) begin
                  next_state = BCCD_SEND;
               end else if (capture_en) begin
                  next_bit_pos = bit_pos + 5'h01;
               end
            end
            BCCD_SEND: begin
               if (send_bit && out_left == 5'h01) begin
                  next_state = BCCD_DONE;
               end
            end
            BCCD_DONE: begin
               next_state = BCCD_DONE;
            end
            default: begin
               next_state = BCCD_WAIT_START;
               next_bit_pos = BCCD_POS_START;
            end
         endcase
      end
   end

   // Result frame: MSB first, optional LSB-first copy, then status
   wire [9:0] result_rev = {<<{i_adc_result}};
   wire [27:0] frame_msb = {i_adc_result, i_status, 10'h000};
   wire [27:0] frame_both = {i_adc_result, result_rev, i_status};
   wire [27:0] frame = cfg.high_bit_first ? frame_msb : frame_both;
   wire [4:0] frame_len = cfg.high_bit_first ? BCCD_LEN_MSB_ONLY :
      BCCD_LEN_BOTH;

   // Sequencer state and output shifter
   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state <= BCCD_WAIT_START;
         bit_pos <= BCCD_POS_START;
         out_sr <= 28'h0000000;
         out_left <= 5'h00;
         o_dout <= 1'b0;
         o_dout_en_b <= 1'b1;
      end else if (i_ce) begin
         state <= next_state;
         bit_pos <= next_bit_pos;
         if (!cs_low) begin
            o_dout_en_b <= 1'b1;
         end else if (word_done) begin
            out_sr <= frame;
            out_left <= frame_len;
         end else if (send_bit) begin
            o_dout <= out_sr[27];
            o_dout_en_b <= 1'b0;
            out_sr <= {out_sr[26:0], 1'b0};
            out_left <= out_left - 5'h01;
         end
      end
   end

   // Field decode into the analog controls
   wire pd = cfg.power_down_bit;
   wire [1:0] mode_bits = {cfg.operating_mode_high, cfg.operating_mode_low};
   wire run_charge = !pd && (mode_bits == BCCD_CHARGE);
   wire run_discharge = !pd && (mode_bits == BCCD_DISCHARGE);
   wire run_gauge = !pd && (mode_bits == BCCD_GAUGE);
   wire [4:0] next_divide_by = {1'b0, cfg.attenuator_ratio} + 5'h01;
   wire duty_ok = (cfg.loop_duty_ratio <= BCCD_DUTY_FULL);
   wire [4:0] next_loop_slots = duty_ok ?
      5'(BCCD_ONE_SLOT << cfg.loop_duty_ratio) : 5'h00;
   wire fault_clr = cfg.fault_latch_clear;

   // Fail-safe limit and timer decode
   wire timeout_off = (cfg.timeout_select == BCCD_TIMEOUT_OFF);
   wire [8:0] limit_min = 9'(BCCD_TIMEOUT_BASE_MIN << cfg.timeout_select);
   wire minute_tick = (prescale == MINUTE_CYCLES - 34'h1);
   wire timer_run = run_charge && !o_timeout;
   wire timeout_set = timer_run && !timeout_off &&
      (minutes >= limit_min);

   // Fail-safe charge timer in minutes
   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         prescale <= 34'h000000000;
         minutes <= 9'h000;
      end else if (i_ce) begin
         if (fault_clr) begin
            prescale <= 34'h000000000;
            minutes <= 9'h000;
         end else if (timer_run) begin
            prescale <= minute_tick ? 34'h000000000 : prescale + 34'h1;
            if (minute_tick && minutes != 9'h1FF) begin
               minutes <= minutes + 9'h001;
            end
         end
      end
   end

   // Registered controls; timeout flag set wins over clear
   always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_mode <= 2'h0;
         o_power_down <= 1'b0;
         o_analog_on <= 1'b0;
         o_regulator_on <= 1'b0;
         o_divider_connect <= 1'b0;
         o_discharge_en <= 1'b0;
         o_charge_en <= 1'b0;
         o_gauge_en <= 1'b0;
         o_adc_ref_sense <= 1'b0;
         o_adc_source <= 3'h0;
         o_divide_by <= 5'h01;
         o_loop_slots <= 5'h01;
         o_sense_ref <= 2'h0;
         o_fault_clear <= 1'b0;
         o_timeout <= 1'b0;
      end else if (i_ce) begin
         o_mode <= mode_bits;
         o_power_down <= pd;
         o_analog_on <= !pd;
         o_regulator_on <= !pd;
         o_divider_connect <= !pd && !run_gauge;
         o_discharge_en <= run_discharge && !o_timeout;
         o_charge_en <= timer_run && !timeout_set;
         o_gauge_en <= run_gauge;
         o_adc_ref_sense <= cfg.adc_input_polarity;
         o_adc_source <= cfg.adc_source_select;
         o_divide_by <= next_divide_by;
         o_loop_slots <= next_loop_slots;
         o_sense_ref <= {cfg.sense_reference_select1,
            cfg.sense_reference_select0};
         o_fault_clear <= fault_clr;
         o_timeout <= timeout_set || (o_timeout && !fault_clr);
      end
   end

   // Checks on the decoder and sequencer
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_b);

   a_reset_clears_word: assert property (
      @(posedge i_sys_clk) disable iff (1'b0)
      !i_rst_b |-> cfg_word == BCCD_CFG_RESET)
      else $error("word not cleared in reset");

   a_zero_no_start: assert property (
      in_wait && sclk_rise && !din_bit && i_ce |=> in_wait)
      else $error("zero bit left the start wait");

   a_mode_bit_early: assert property (
      (capture_en && i_ce && bit_pos == 5'h03) ##1 i_ce
      |=> o_mode[1] == $past(din_bit, 2))
      else $error("mode bit not applied at once");

   a_shutdown_all_off: assert property (
      o_power_down |-> !o_analog_on && !o_regulator_on &&
      !o_divider_connect && !o_charge_en && !o_discharge_en &&
      !o_gauge_en)
      else $error("circuit left on in shutdown");

   a_idle_quiet: assert property (
      o_mode == 2'h0 |-> !o_charge_en && !o_discharge_en && !o_gauge_en)
      else $error("idle mode with a loop enabled");

   a_frame_length: assert property (
      word_done && i_ce |=> out_left ==
      ($past(cfg.high_bit_first) ? BCCD_LEN_MSB_ONLY : BCCD_LEN_BOTH))
      else $error("wrong output frame length");

   a_clear_on_select: assert property (
      cs_rise && i_ce |=> !cfg.fault_latch_clear)
      else $error("fault clear kept after select high");

   a_clear_resets_timer: assert property (
      o_fault_clear |-> minutes == 9'h000 && !o_timeout)
      else $error("fault clear did not reset timer");

   a_timeout_cause: assert property (
      $rose(o_timeout) |-> $past(!timeout_off) &&
      $past(minutes) >= $past(limit_min))
      else $error("timeout without reaching limit");

   a_divider_ratio: assert property (
      i_ce ##1 i_ce |=> o_divide_by == {1'b0, $past(cfg.attenuator_ratio)}
      + 5'h01 && o_divide_by != 5'h00)
      else $error("divider ratio wrong");

   c_full_word: cover property (word_done && i_ce);
   c_both_orders: cover property (send_bit && !cfg.high_bit_first);
   c_shutdown: cover property ($rose(o_power_down));
   c_timeout: cover property ($rose(o_timeout));

endmodule : bccd_top

// *** tb/bccd_host.sv ***
// Host model driving the serial command link
`timescale 1ns/1ps
module bccd_host import bccd_pkg::*; (
   input wire logic i_dout,
   output logic o_cs_b,
   output logic o_sclk,
   output logic o_din,
   output logic o_got,
   output logic [27:0] o_bits
);
   int pos;

   // Idle link: select high, clock parked low
   initial begin
      o_cs_b = 1'b1;
      o_sclk = 1'b0;
      o_din = 1'b0;
      o_got = 1'b0;
      o_bits = 28'h0000000;
      pos = 0;
   end

   // One link clock, bit set up ahead of the rise
   task automatic tick(input logic b);
      o_din = b;
      #24 o_sclk = 1'b1;
      #24 o_sclk = 1'b0;
   endtask : tick

   // Command word in, then result and status out
   task automatic xfer(input logic [21:0] w);
      pos = 0;
      o_bits = 28'h0000000;
      o_cs_b = 1'b0;
      // Offset keeps link edges off the system clock edges
      #100.3;
      repeat (4) tick(1'b0);
      for (int i = 0; i < 22; i++) begin
         pos = i + 1;
         tick(w[i]);
      end
      // Released input toggles; select low 44 or 54 clocks
      for (int i = 0; i < (w[4] ? 18 : 28); i++) begin
         o_din = ~o_din;
         #24 o_sclk = 1'b1;
         #24 o_bits = {o_bits[26:0], i_dout};
         o_sclk = 1'b0;
      end
      #1 o_got = 1'b1;
      #1 o_got = 1'b0;
      o_cs_b = 1'b1;
      #100;
   endtask : xfer
endmodule : bccd_host

// *** tb/tb_top.sv ***
// Self-checking bench for the command decoder
`timescale 1ns/1ps
module tb_top import bccd_pkg::*; ;
   typedef struct packed {
      logic [27:0] frame;
      logic [25:0] ctl;
   } bccd_note_t;

   logic clk, rst_b, cs_b, sclk, din, dout, den_b, pd, ana, rg, dc;
   logic dis, chg, gau, rs, fclr, tmo, got;
   logic [9:0] adc;
   logic [7:0] stat;
   logic [1:0] mode, sref;
   logic [2:0] src;
   logic [4:0] divby, slots;
   logic [27:0] bits;
   logic [25:0] ctl_now;
   bccd_note_t notes[$];
   int bad_count = 0;
   int num_checks = 0;
   int cyc = 0;
   int n;

   assign ctl_now = {mode, pd, ana, rg, dc, dis, chg, gau, rs, src, divby,
      slots, fclr, sref};

   bccd_top #(.MINUTE_CYCLES(34'd200)) dut (.i_sys_clk(clk), .i_rst_b(rst_b),
      .i_ce(1'b1), .i_cs_b(cs_b), .i_sclk(sclk), .i_din(din),
      .i_adc_result(adc), .i_status(stat), .o_dout(dout),
      .o_dout_en_b(den_b), .o_mode(mode), .o_power_down(pd),
      .o_analog_on(ana), .o_regulator_on(rg), .o_divider_connect(dc),
      .o_discharge_en(dis), .o_charge_en(chg), .o_gauge_en(gau),
      .o_adc_ref_sense(rs), .o_adc_source(src), .o_divide_by(divby),
      .o_loop_slots(slots), .o_sense_ref(sref), .o_fault_clear(fclr),
      .o_timeout(tmo));

   bccd_host host (.i_dout(dout), .o_cs_b(cs_b), .o_sclk(sclk), .o_din(din),
      .o_got(got), .o_bits(bits));

   // Verdict and end of run
   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : test_done

   // One comparison
   task automatic chk(input logic [27:0] a, input logic [27:0] e,
      input string m);
      num_checks++;
      if (a !== e) begin
         bad_count++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask : chk

   // Expected decoded controls, no timeout pending
   function automatic logic [25:0] exp_ctl(input logic [21:0] w);
      logic p;
      logic [1:0] m;
      logic [4:0] sl;
      p = w[12];
      m = {w[2], w[1]};
      sl = (w[15:13] < 3'h5) ? (5'h01 << w[15:13]) : 5'h00;
      return {m, p, !p, !p, !p && m != 2'h3, !p && m == 2'h1,
         !p && m == 2'h2, !p && m == 2'h3, w[3], w[7:5],
         5'({1'b0, w[11:8]} + 5'h01), sl, w[16], w[21:20]};
   endfunction : exp_ctl

   // Expected output frame
   function automatic logic [27:0] exp_frame(input logic [21:0] w,
      input logic [9:0] r, input logic [7:0] s);
      logic [9:0] rv;
      for (int i = 0; i < 10; i++) rv[i] = r[9 - i];
      return w[4] ? {10'h000, r, s} : {r, rv, s};
   endfunction : exp_frame

   // Random legal word, fault clear kept set
   function automatic logic [21:0] rnd_word(input logic msb_only);
      logic [21:0] w;
      w = 22'($urandom);
      w[0] = 1'b1;
      w[4] = msb_only;
      w[7:5] = 3'($urandom_range(4));
      w[15:13] = 3'($urandom_range(4));
      w[16] = 1'b1;
      return w;
   endfunction : rnd_word

   // Drive one transaction and note its outcome
   task automatic send(input logic [21:0] w);
      @(posedge clk);
      #1;
      adc = 10'($urandom);
      stat = 8'($urandom);
      notes.push_back('{exp_frame(w, adc, stat), exp_ctl(w)});
      fork
         host.xfer(w);
         begin
            wait (host.pos == 5);
            chk(28'(mode), 28'({w[2], w[1]}), "early mode");
         end
      join
      repeat (8) @(posedge clk);
      #1;
      chk(28'({fclr, den_b}), 28'h1, "clear or enable");
   endtask : send

   // Result watcher
   always @(posedge got) begin
      bccd_note_t nt;
      nt = notes.pop_front();
      chk(bits, nt.frame, "frame bits");
      chk(28'(ctl_now), 28'(nt.ctl),
         "controls");
      chk(28'({ana, rg, dc}), 28'(nt.ctl[22:20]), "power");
      chk(28'(den_b), 28'h0, "output enable");
   end

   // System clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // Hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         bad_count++;
         $display("[FAIL] %0t run too long", $time);
         test_done();
      end
   end

   // Main sequence
   initial begin
      rst_b = 1'b0;
      adc = 10'h000;
      stat = 8'h00;
      void'($urandom(49));
      repeat (10) @(posedge clk);
      #1 rst_b = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk(28'({mode, pd, src, divby, slots, sref, fclr, tmo, den_b}),
         28'h0000421, "reset state");
      for (int i = 0; i < 14; i++) begin
         send(i == 0 ? 22'h3F9F8F : i == 1 ? 22'h000001 : rnd_word(i[0]));
      end
      // Charge with timeout codes 0, 1 and 7
      for (int c = 0; c < 3; c++) begin
         send({2'h0, (c == 2) ? 3'h7 : 3'(c), 1'b1, 3'h4, 1'b0, 4'h0,
            3'h0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1});
         n = 0;
         // Timer started about 24 cycles before this count began
         while (tmo !== 1'b1 && n < 5000) begin
            @(posedge clk);
            #1;
            n++;
         end
         chk(28'(c == 2 ? n == 5000 :
            (n > ((1000 << c) - 34) && n < ((1000 << c) - 14))),
            28'h1, "timeout moment");
         chk(28'(chg), 28'(c == 2), "charge gate");
      end
      test_done();
   end
endmodule : tb_top
